// File: pcc_top.sv
// pcc_top: edge capture flags and compare-and-set unit with register port
// assumes counters, raw fast input pins and a scan-end pulse all on clk
`timescale 1ns/10ps
`default_nettype none

// Contract
// - a filtered rising edge sets that port's capture flag when enabled
// - capture needs both global interrupt enable and port capture enable
// - a port with capture disabled never gets its flag set
// - counter equal to 32-bit compare value sets the target, at once except Y20 and up
// - compare uses a 32-bit fast counter and 32-bit compare value
// - Y0-Y17 immediate, Y20 and up after scan, relay bits immediate
// - interrupt target fires only with its enable and global enable on
// - counter interrupt disable bit blocks all eight counter interrupts
// - a set target stays set until explicitly reset
// - a match is seen counting up or counting down
// - only pulse-driven counter changes are compared, never software loads
// - fewer than eight compares are active at once
// - an interrupt match gives exactly one pulse per match
// - filter setting in 250 ns units, range 1 to 100, reset 1
// - global interrupt off blocks all interrupt responses
module pcc_top #(
    parameter int NSLOT = pcc_pkg::NSLOT,
    parameter int NCNT = pcc_pkg::NCNT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [pcc_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [pcc_pkg::NPORT-1:0] fast_input,
    input wire pcc_pkg::pcc_cnt_t cnt [NCNT],
    input wire logic scan_end,
    output logic [pcc_pkg::NOUT-1:0] y_fast,
    output logic [pcc_pkg::NOUT-1:0] y_slow,
    output logic [pcc_pkg::NOUT-1:0] relay,
    output logic [pcc_pkg::NIRQ-1:0] counter_irq
);
    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic global_irq_on;
    logic counter_irq_disable;
    logic [pcc_pkg::NPORT-1:0] capture_enable;
    logic [pcc_pkg::NIRQ-1:0] irq_enable;
    logic [6:0] input_filter_setting;
    logic [2:0] slot_sel;
    logic next_global_irq_on;
    logic next_counter_irq_disable;
    logic [pcc_pkg::NPORT-1:0] next_capture_enable;
    logic [pcc_pkg::NIRQ-1:0] next_irq_enable;
    logic [6:0] next_input_filter_setting;
    logic [2:0] next_slot_sel;
    logic wr_ctrl;
    logic wr_filt;

    assign wr_ctrl = wr && (addr == pcc_pkg::A_CTRL);
    assign wr_filt = wr && (addr == pcc_pkg::A_FILT);

    always_comb begin
        next_global_irq_on = global_irq_on;
        next_counter_irq_disable = counter_irq_disable;
        next_capture_enable = capture_enable;
        next_irq_enable = irq_enable;
        next_input_filter_setting = input_filter_setting;
        next_slot_sel = slot_sel;
        if (wr_ctrl) begin
            next_global_irq_on = wdata[pcc_pkg::CTRL_GLB];
            next_counter_irq_disable = wdata[pcc_pkg::CTRL_CDIS];
            next_capture_enable = wdata[pcc_pkg::CTRL_CAPEN +: pcc_pkg::NPORT];
            next_irq_enable = wdata[pcc_pkg::CTRL_IRQEN +: pcc_pkg::NIRQ];
        end
        // out-of-range settings are dropped, keeping the old value
        if (wr_filt && wdata[6:0] >= pcc_pkg::FILT_MIN && wdata[6:0] <= pcc_pkg::FILT_MAX
            && wdata[31:7] == 25'h000_0000) begin
            next_input_filter_setting = wdata[6:0];
        end
        if (wr && addr == pcc_pkg::A_SEL) begin
            next_slot_sel = wdata[2:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            global_irq_on <= 1'b0;
            counter_irq_disable <= 1'b0;
            capture_enable <= '0;
            irq_enable <= '0;
            input_filter_setting <= pcc_pkg::FILT_RST;
            slot_sel <= 3'h0;
        end else begin
            global_irq_on <= next_global_irq_on;
            counter_irq_disable <= next_counter_irq_disable;
            capture_enable <= next_capture_enable;
            irq_enable <= next_irq_enable;
            input_filter_setting <= next_input_filter_setting;
            slot_sel <= next_slot_sel;
        end
    end

    // ------------------------------------------------------------
    // edge capture
    // ------------------------------------------------------------
    logic [pcc_pkg::NPORT-1:0] rise;
    logic [pcc_pkg::NPORT-1:0] capture_flag;
    logic [pcc_pkg::NPORT-1:0] next_capture_flag;
    logic [pcc_pkg::NPORT-1:0] cap_set;
    logic [pcc_pkg::NPORT-1:0] cap_clr;

    pcc_edge_filter #(
        .NP(pcc_pkg::NPORT)
    ) u_filter (
        .clk(clk),
        .rst_b(rst_b),
        .pins(fast_input),
        .setting(input_filter_setting),
        .rise(rise)
    );

    assign cap_set = rise & capture_enable & {pcc_pkg::NPORT{global_irq_on}};
    assign cap_clr = (wr && addr == pcc_pkg::A_CAPT) ? wdata[pcc_pkg::NPORT-1:0] : '0;

    always_comb begin
        // set wins over a clear in the same cycle; no edge counting
        next_capture_flag = (capture_flag & ~cap_clr) | cap_set;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capture_flag <= '0;
        end else begin
            capture_flag <= next_capture_flag;
        end
    end

    // ------------------------------------------------------------
    // compare slots
    // ------------------------------------------------------------
    pcc_pkg::pcc_slot_t slot_cfg [NSLOT];
    logic [31:0] slot_val [NSLOT];
    logic [NSLOT-1:0] match;
    logic [pcc_pkg::NOUT-1:0] fast_m [NSLOT];
    logic [pcc_pkg::NOUT-1:0] slow_m [NSLOT];
    logic [pcc_pkg::NOUT-1:0] relay_m [NSLOT];
    logic [pcc_pkg::NIRQ-1:0] irq_m [NSLOT];

    // slot count kept below eight so at most seven compares run at once
    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
        pcc_pkg::pcc_slot_t next_cfg;
        logic [31:0] next_val;
        logic hit;

        assign hit = wr && (slot_sel == 3'(s));

        always_comb begin
            next_cfg = slot_cfg[s];
            next_val = slot_val[s];
            if (hit && addr == pcc_pkg::A_CFG) begin
                next_cfg.active = wdata[pcc_pkg::CFG_ACT];
                next_cfg.kind = pcc_pkg::pcc_kind_t'(wdata[pcc_pkg::CFG_KIND +: 2]);
                next_cfg.idx = wdata[pcc_pkg::CFG_IDX +: 4];
                next_cfg.cnt_sel = wdata[pcc_pkg::CFG_CNT +: 2];
            end
            if (hit && addr == pcc_pkg::A_VAL) begin
                next_val = wdata;
            end
        end

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                slot_cfg[s] <= '0;
                slot_val[s] <= 32'h0000_0000;
            end else begin
                slot_cfg[s] <= next_cfg;
                slot_val[s] <= next_val;
            end
        end

        // equality on a counting step, so approach from either direction matches
        pcc_cmp_slot #(
            .NC(NCNT)
        ) u_cmp (
            .cnt(cnt),
            .cfg(slot_cfg[s]),
            .cmp_value(slot_val[s]),
            .match(match[s])
        );

        always_comb begin
            fast_m[s] = '0;
            slow_m[s] = '0;
            relay_m[s] = '0;
            irq_m[s] = '0;
            if (match[s]) begin
                case (slot_cfg[s].kind)
                    pcc_pkg::TK_FAST: fast_m[s][slot_cfg[s].idx] = 1'b1;
                    pcc_pkg::TK_SLOW: slow_m[s][slot_cfg[s].idx] = 1'b1;
                    pcc_pkg::TK_RELAY: relay_m[s][slot_cfg[s].idx] = 1'b1;
                    pcc_pkg::TK_IRQ: irq_m[s][slot_cfg[s].idx[2:0]] = 1'b1;
                    default: fast_m[s] = '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // compare targets
    // ------------------------------------------------------------
    logic [pcc_pkg::NOUT-1:0] fast_set;
    logic [pcc_pkg::NOUT-1:0] slow_set;
    logic [pcc_pkg::NOUT-1:0] relay_set;
    logic [pcc_pkg::NIRQ-1:0] irq_req;
    logic [pcc_pkg::NIRQ-1:0] irq_gated;
    logic [pcc_pkg::NOUT-1:0] slow_pend;
    logic [pcc_pkg::NOUT-1:0] fast_clr;
    logic [pcc_pkg::NOUT-1:0] slow_clr;
    logic [pcc_pkg::NOUT-1:0] relay_clr;
    logic [pcc_pkg::NOUT-1:0] next_y_fast;
    logic [pcc_pkg::NOUT-1:0] next_y_slow;
    logic [pcc_pkg::NOUT-1:0] next_relay;
    logic [pcc_pkg::NOUT-1:0] next_slow_pend;
    logic [pcc_pkg::NIRQ-1:0] next_counter_irq;

    assign fast_clr = (wr && addr == pcc_pkg::A_YOUT) ? wdata[pcc_pkg::NOUT-1:0] : '0;
    assign slow_clr = (wr && addr == pcc_pkg::A_YOUT) ?
        wdata[pcc_pkg::YOUT_SLOW +: pcc_pkg::NOUT] : '0;
    assign relay_clr = (wr && addr == pcc_pkg::A_RELAY) ? wdata[pcc_pkg::NOUT-1:0] : '0;
    // global off or counter disable blocks every counter interrupt
    assign irq_gated = irq_req & irq_enable
        & {pcc_pkg::NIRQ{global_irq_on & ~counter_irq_disable}};

    always_comb begin
        fast_set = '0;
        slow_set = '0;
        relay_set = '0;
        irq_req = '0;
        for (int s = 0; s < NSLOT; s++) begin
            fast_set = fast_set | fast_m[s];
            slow_set = slow_set | slow_m[s];
            relay_set = relay_set | relay_m[s];
            irq_req = irq_req | irq_m[s];
        end
        // targets hold until software clears; a set beats a clear
        next_y_fast = (y_fast & ~fast_clr) | fast_set;
        next_relay = (relay & ~relay_clr) | relay_set;
        // slow outputs wait for the scan-end pulse
        next_slow_pend = scan_end ? slow_set : (slow_pend | slow_set);
        next_y_slow = (y_slow & ~slow_clr) | (scan_end ? slow_pend : '0);
        // one pulse per step-qualified match, never held
        next_counter_irq = irq_gated;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            y_fast <= '0;
            y_slow <= '0;
            relay <= '0;
            slow_pend <= '0;
            counter_irq <= '0;
        end else begin
            y_fast <= next_y_fast;
            y_slow <= next_y_slow;
            relay <= next_relay;
            slow_pend <= next_slow_pend;
            counter_irq <= next_counter_irq;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = pcc_pkg::RD_ZERO;
        if (rd) begin
            case (addr)
                pcc_pkg::A_CTRL: begin
                    next_rdata[pcc_pkg::CTRL_GLB] = global_irq_on;
                    next_rdata[pcc_pkg::CTRL_CDIS] = counter_irq_disable;
                    next_rdata[pcc_pkg::CTRL_CAPEN +: pcc_pkg::NPORT] = capture_enable;
                    next_rdata[pcc_pkg::CTRL_IRQEN +: pcc_pkg::NIRQ] = irq_enable;
                end
                pcc_pkg::A_FILT: next_rdata[6:0] = input_filter_setting;
                pcc_pkg::A_CAPT: next_rdata[pcc_pkg::NPORT-1:0] = capture_flag;
                pcc_pkg::A_YOUT: next_rdata = {y_slow, y_fast};
                pcc_pkg::A_RELAY: next_rdata[pcc_pkg::NOUT-1:0] = relay;
                pcc_pkg::A_SEL: next_rdata[2:0] = slot_sel;
                pcc_pkg::A_CFG: begin
                    if (int'(slot_sel) < NSLOT) begin
                        next_rdata[pcc_pkg::CFG_ACT] = slot_cfg[slot_sel].active;
                        next_rdata[pcc_pkg::CFG_KIND +: 2] = slot_cfg[slot_sel].kind;
                        next_rdata[pcc_pkg::CFG_IDX +: 4] = slot_cfg[slot_sel].idx;
                        next_rdata[pcc_pkg::CFG_CNT +: 2] = slot_cfg[slot_sel].cnt_sel;
                    end
                end
                pcc_pkg::A_VAL: begin
                    if (int'(slot_sel) < NSLOT) begin
                        next_rdata = slot_val[slot_sel];
                    end
                end
                default: next_rdata = pcc_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= pcc_pkg::RD_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic any_step;
    always_comb begin
        any_step = 1'b0;
        for (int c = 0; c < NCNT; c++) begin
            any_step = any_step | cnt[c].step;
        end
    end

    sequence fast_match_s;
        |fast_set;
    endsequence

    sequence fast_held_s;
        (y_fast & $past(fast_set)) == $past(fast_set);
    endsequence

    capture_set_a: assert property (
        |cap_set |=> ((capture_flag & $past(cap_set)) == $past(cap_set)))
        else $error("capture flag not set on enabled edge");
    capture_gate_a: assert property (
        ##1 ((capture_flag & ~$past(capture_flag) & ~$past(cap_set)) == '0))
        else $error("capture flag set without enabled edge");
    capture_hold_a: assert property (
        ##1 ((~capture_flag & $past(capture_flag) & ~$past(cap_clr)) == '0))
        else $error("capture flag dropped without software clear");
    filter_range_a: assert property (
        input_filter_setting >= pcc_pkg::FILT_MIN && input_filter_setting <= pcc_pkg::FILT_MAX)
        else $error("filter setting out of range");
    fast_set_a: assert property (
        fast_match_s |=> fast_held_s)
        else $error("immediate output not set after match");
    fast_cause_a: assert property (
        ##1 ((y_fast & ~$past(y_fast)) != '0) |-> $past(any_step))
        else $error("immediate output rose without counter step");
    slow_scan_a: assert property (
        ##1 ((y_slow & ~$past(y_slow)) != '0) |-> $past(scan_end))
        else $error("late output changed outside scan end");
    irq_block_a: assert property (
        (counter_irq_disable || !global_irq_on) |=> counter_irq == '0)
        else $error("counter interrupt while blocked");
    irq_pulse_a: assert property (
        |counter_irq |=> ((counter_irq & $past(counter_irq)) == '0))
        else $error("counter interrupt held longer than one cycle");
    relay_keep_a: assert property (
        ##1 ((~relay & $past(relay) & ~$past(relay_clr)) == '0))
        else $error("relay target dropped without reset");
endmodule
`default_nettype wire

// File: pcc_pkg.sv
// pcc_pkg: constants, register map and carrier types for the capture/compare block
// assumes a single 20 MHz system clock and the plain register port of pcc_top
package pcc_pkg;

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int NPORT = 8;
    localparam int NSLOT = 7;
    localparam int NCNT = 4;
    localparam int NOUT = 16;
    localparam int NIRQ = 8;
    localparam int CLK_PERIOD_NS = 50;
    localparam int FILT_UNIT_NS = 250;
    localparam int FILT_UNIT_CYC = (FILT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] FILT_MIN = 7'h01;
    localparam logic [6:0] FILT_MAX = 7'h64;
    localparam logic [6:0] FILT_RST = 7'h01;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_FILT = 5'h04;
    localparam logic [4:0] A_CAPT = 5'h08;
    localparam logic [4:0] A_YOUT = 5'h0c;
    localparam logic [4:0] A_RELAY = 5'h10;
    localparam logic [4:0] A_SEL = 5'h14;
    localparam logic [4:0] A_CFG = 5'h18;
    localparam logic [4:0] A_VAL = 5'h1c;
    localparam int CTRL_GLB = 0;
    localparam int CTRL_CDIS = 1;
    localparam int CTRL_CAPEN = 8;
    localparam int CTRL_IRQEN = 16;
    localparam int CFG_ACT = 0;
    localparam int CFG_KIND = 1;
    localparam int CFG_IDX = 4;
    localparam int CFG_CNT = 8;
    localparam int YOUT_SLOW = 16;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TK_FAST = 2'h0,
        TK_SLOW = 2'h1,
        TK_RELAY = 2'h2,
        TK_IRQ = 2'h3
    } pcc_kind_t;

    typedef struct packed {
        logic step;
        logic [31:0] value;
    } pcc_cnt_t;

    typedef struct packed {
        logic active;
        pcc_kind_t kind;
        logic [3:0] idx;
        logic [1:0] cnt_sel;
    } pcc_slot_t;

endpackage

// File: pcc_edge_filter.sv
// pcc_edge_filter: per-port stability filter and rising-edge pulse
// assumes fast inputs synchronous to clk; setting in 250 ns units
`timescale 1ns/10ps
`default_nettype none
module pcc_edge_filter #(
    parameter int NP = pcc_pkg::NPORT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NP-1:0] pins,
    input wire logic [6:0] setting,
    output logic [NP-1:0] rise
);
    logic [9:0] limit;

    // filter time in cycles; short pulses never reach the level
    assign limit = 10'(setting) * 10'(pcc_pkg::FILT_UNIT_CYC);

    for (genvar i = 0; i < NP; i++) begin : g_port
        logic level;
        logic [9:0] cnt;
        logic next_level;
        logic [9:0] next_cnt;
        logic next_rise;

        always_comb begin
            next_level = level;
            next_cnt = 10'h000;
            next_rise = 1'b0;
            if (pins[i] != level) begin
                if (cnt + 10'h001 >= limit) begin
                    next_level = pins[i];
                    next_rise = pins[i];
                end else begin
                    next_cnt = cnt + 10'h001;
                end
            end
        end

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                level <= 1'b0;
                cnt <= 10'h000;
                rise[i] <= 1'b0;
            end else begin
                level <= next_level;
                cnt <= next_cnt;
                rise[i] <= next_rise;
            end
        end
    end
endmodule
`default_nettype wire

// File: pcc_cmp_slot.sv
// pcc_cmp_slot: one 32-bit equality comparator on a selected counter
// assumes counter step pulses mark pulse-driven changes of the value
`timescale 1ns/10ps
`default_nettype none
module pcc_cmp_slot #(
    parameter int NC = pcc_pkg::NCNT
) (
    input wire pcc_pkg::pcc_cnt_t cnt [NC],
    input wire pcc_pkg::pcc_slot_t cfg,
    input wire logic [31:0] cmp_value,
    output logic match
);
    pcc_pkg::pcc_cnt_t sel;

    assign sel = cnt[cfg.cnt_sel];
    // only a counting step can match: software loads carry no step
    assign match = cfg.active & sel.step & (sel.value == cmp_value);
endmodule
`default_nettype wire

// File: pcc_far_model.sv
// pcc_far_model: fast counters and scan-end source facing pcc_top
// assumes one-cycle op and scan_go strobes from the bench on clk
`timescale 1ns/10ps
`default_nettype none
module pcc_far_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] op,
    input wire logic [1:0] k,
    input wire logic [31:0] lv,
    input wire logic scan_go,
    output var pcc_pkg::pcc_cnt_t cnt [pcc_pkg::NCNT],
    output logic scan_end
);
    // ----------------------------------------
    // counters: op 0 idle, 1 up, 2 down, 3 load
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < pcc_pkg::NCNT; i++) begin
                cnt[i] <= '0;
            end
            scan_end <= 1'b0;
        end else begin
            scan_end <= scan_go;
            for (int i = 0; i < pcc_pkg::NCNT; i++) begin
                cnt[i].step <= 1'b0;
            end
            // idle counter keeps its value with step low, so nothing can match
            case (op)
                2'h1: cnt[k] <= '{1'b1, cnt[k].value + 32'h0000_0001};
                2'h2: cnt[k] <= '{1'b1, cnt[k].value - 32'h0000_0001};
                2'h3: cnt[k] <= '{1'b0, lv};
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: test_pulse_capture_compare_set.sv
// test_pulse_capture_compare_set: self-checking bench for pcc_top
// assumes pcc_far_model drives counters and scan end; bench drives bus and pins
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_pulse_capture_compare_set;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic [31:0] rdata;
    logic [7:0] fast_input = 8'h00;
    logic [1:0] op = 2'h0;
    logic [1:0] k = 2'h0;
    logic [31:0] lv = 32'h0000_0000;
    logic scan_go = 1'b0;
    logic scan_end;
    pcc_pkg::pcc_cnt_t cnt [pcc_pkg::NCNT];
    logic [15:0] y_fast;
    logic [15:0] y_slow;
    logic [15:0] relay;
    logic [7:0] counter_irq;
    logic [7:0] n_irq1 = 8'h00;
    logic [7:0] n_irq_other = 8'h00;
    logic [31:0] expq [$];
    logic [31:0] rv;
    logic [31:0] cv;
    logic [31:0] blk [4] = '{32'h0002_0f03, 32'h0002_0f00, 32'h0000_0f01, 32'h0002_0f01};
    int errors = 0;
    int n_compared = 0;

    pcc_far_model far (.clk(clk), .rst_b(rst_b), .op(op), .k(k), .lv(lv),
        .scan_go(scan_go), .cnt(cnt), .scan_end(scan_end));
    pcc_top uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .fast_input(fast_input), .cnt(cnt), .scan_end(scan_end),
        .y_fast(y_fast), .y_slow(y_slow), .relay(relay), .counter_irq(counter_irq));

    always #25 clk = ~clk;

    // ----------------------------------------
    // watcher: read data one cycle after rd
    // ----------------------------------------
    always @(posedge clk) begin
        if (rd_q) begin
            rv = expq.pop_front();
            `CHK(rdata, rv)
        end
        rd_q <= rd;
        n_irq1 <= n_irq1 + {7'h00, counter_irq[1]};
        if ((counter_irq & 8'hfd) !== 8'h00) begin
            n_irq_other <= n_irq_other + 8'h01;
        end
    end

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // pins are synchronous; width in clk cycles
    task automatic pulse(input int p, input int w);
        @(posedge clk);
        fast_input[p] <= 1'b1;
        repeat (w) @(posedge clk);
        fast_input[p] <= 1'b0;
        repeat (12) @(posedge clk);
    endtask

    task automatic cop(input logic [1:0] c, input logic [1:0] o, input logic [31:0] v);
        @(posedge clk);
        k <= c;
        op <= o;
        lv <= v;
        @(posedge clk);
        op <= 2'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic scan();
        @(posedge clk);
        scan_go <= 1'b1;
        @(posedge clk);
        scan_go <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic slot(input logic [2:0] s, input logic [1:0] kd, input logic [3:0] ix,
        input logic [1:0] c, input logic [31:0] v);
        wr_reg(pcc_pkg::A_SEL, {29'h0, s});
        wr_reg(pcc_pkg::A_CFG, {22'h0, c, ix, 1'b0, kd, 1'b1});
        wr_reg(pcc_pkg::A_VAL, v);
        rd_reg(pcc_pkg::A_CFG, {22'h0, c, ix, 1'b0, kd, 1'b1});
        rd_reg(pcc_pkg::A_VAL, v);
    endtask

    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard, far beyond the roughly 300 cycles of the sequence
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(99860));
        cv = $urandom;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(pcc_pkg::A_FILT, 32'h0000_0001);
        rd_reg(pcc_pkg::A_CTRL, 32'h0000_0000);
        wr_reg(pcc_pkg::A_FILT, 32'h0000_0000);
        wr_reg(pcc_pkg::A_FILT, 32'h0000_0065);
        rd_reg(pcc_pkg::A_FILT, 32'h0000_0001);
        wr_reg(pcc_pkg::A_FILT, 32'h0000_0064);
        rd_reg(pcc_pkg::A_FILT, 32'h0000_0064);
        wr_reg(pcc_pkg::A_FILT, 32'h0000_0001);
        wr_reg(pcc_pkg::A_SEL, 32'h0000_0007);
        rd_reg(pcc_pkg::A_SEL, 32'h0000_0007);
        rd_reg(pcc_pkg::A_CFG, 32'h0000_0000);
        wr_reg(pcc_pkg::A_CTRL, 32'h0002_0f01);
        pulse(0, 8);
        pulse(4, 8);
        pulse(1, 4);
        rd_reg(pcc_pkg::A_CAPT, 32'h0000_0001);
        pulse(0, 8);
        rd_reg(pcc_pkg::A_CAPT, 32'h0000_0001);
        wr_reg(pcc_pkg::A_CAPT, 32'h0000_00ff);
        rd_reg(pcc_pkg::A_CAPT, 32'h0000_0000);
        wr_reg(pcc_pkg::A_CTRL, 32'h0002_0f00);
        pulse(2, 8);
        rd_reg(pcc_pkg::A_CAPT, 32'h0000_0000);
        slot(3'h0, 2'h0, 4'h3, 2'h0, cv);
        slot(3'h1, 2'h2, 4'h5, 2'h1, 32'h0000_0064);
        slot(3'h2, 2'h1, 4'h2, 2'h2, 32'h0000_0064);
        slot(3'h3, 2'h3, 4'h1, 2'h3, 32'h0000_0007);
        cop(2'h0, 2'h3, cv - 32'h0000_0002);
        cop(2'h0, 2'h1, 32'h0000_0000);
        `CHK(y_fast, 16'h0000)
        cop(2'h0, 2'h1, 32'h0000_0000);
        `CHK(y_fast, 16'h0008)
        cop(2'h0, 2'h1, 32'h0000_0000);
        `CHK(y_fast, 16'h0008)
        cop(2'h1, 2'h3, 32'h0000_0065);
        cop(2'h1, 2'h2, 32'h0000_0000);
        `CHK(relay, 16'h0020)
        cop(2'h2, 2'h3, 32'h0000_0064);
        scan();
        `CHK(y_slow, 16'h0000)
        cop(2'h2, 2'h3, 32'h0000_0063);
        cop(2'h2, 2'h1, 32'h0000_0000);
        `CHK(y_slow, 16'h0000)
        scan();
        `CHK(y_slow, 16'h0004)
        rd_reg(pcc_pkg::A_YOUT, 32'h0004_0008);
        rd_reg(pcc_pkg::A_RELAY, 32'h0000_0020);
        wr_reg(pcc_pkg::A_YOUT, 32'hffff_ffff);
        rd_reg(pcc_pkg::A_YOUT, 32'h0000_0000);
        wr_reg(pcc_pkg::A_CTRL, 32'h0002_0f01);
        cop(2'h3, 2'h3, 32'h0000_0006);
        cop(2'h3, 2'h1, 32'h0000_0000);
        repeat (4) @(posedge clk);
        #1;
        `CHK(n_irq1, 8'h01)
        for (int i = 0; i < 4; i++) begin
            wr_reg(pcc_pkg::A_CTRL, blk[i]);
            cop(2'h3, 2'h3, 32'h0000_0006);
            cop(2'h3, 2'h1, 32'h0000_0000);
            `CHK(n_irq1, (i == 3) ? 8'h02 : 8'h01)
        end
        `CHK(n_irq_other, 8'h00)
        complete_run();
    end
endmodule
`default_nettype wire
